// [edswc_map.svh]
`ifndef EDSWC_MAP_SVH
`define EDSWC_MAP_SVH
// Byte offsets of the register window.
`define EDSWC_CLKCTL_OFFS   12'h000
`define EDSWC_ROM_MAPPING_CONTROL_OFFS   12'h004
`define EDSWC_UNLOCK_OFFS   12'h008
`define EDSWC_DPSEL_OFFS    12'h00c
`define EDSWC_DPTR0_OFFS    12'h010
`define EDSWC_SECONDARY_DATA_POINTER_OFFS    12'h014
`define EDSWC_ADDRSRC_OFFS  12'h018
`define EDSWC_CMD_OFFS      12'h01c
`define EDSWC_STATUS_OFFS   12'h020
// Field positions.
`define EDSWC_STRETCH_MSB   2
`define EDSWC_WAITEN_BIT    7
`define EDSWC_CMD_GO_BIT    0
`define EDSWC_CMD_WR_BIT    1
`define EDSWC_CMD_PTR_BIT   2
// Reset values.
`define EDSWC_STRETCH_RST   3'h1
// Unlock sequence bytes and window length in clocks.
`define EDSWC_UNLOCK_KEY1   8'haa
`define EDSWC_UNLOCK_KEY2   8'h55
`define EDSWC_UNLOCK_WIN    3'h4
// Machine cycle timing.
`define EDSWC_CLK_PER_MC    2'h3
`define EDSWC_C3_PHASE      2'h2
`endif

// [edswc_pkg.sv]
package edswc_pkg;
   typedef enum logic [1:0] {EDSWC_IDLE, EDSWC_FETCH, EDSWC_ACCESS} edswc_state_t;
endpackage

// [edswc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one level coming from a pin.
module edswc_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Level.
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// [edswc_ctrl.sv]
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "edswc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Only external_data_move accesses stretch; other timing is untouched.
// [RULE2] Stretch resets to 1, giving three machine cycles.
// [RULE3] Stretch 0 gives the shortest two-cycle access.
// [RULE4] Access lasts S+2 cycles; strobe 2 clocks at S=0, else 4*S.
// [RULE5] Wait input comes on port4_bit0 alternate function.
// [RULE6] Wait input honoured only while wait_input_enable is set.
// [RULE7] Stretch sets minimum length; waits only add cycles.
// [RULE8] Wait sampled at third_clock_state of each machine cycle, before strobe rises. The code samples it only in the last machine cycle.
// [RULE9] Active wait sample inserts one more machine cycle.
// [RULE10] Wait count unlimited; access ends when wait sampled inactive.
// [RULE11] wait_input_enable writes need the timed_access_unlock sequence.
// [RULE12] Access opens with a four-clock fetch cycle, then addresses.
// [RULE13] Stretch field is bits 2..0 of clock_control_register.
// [RULE14] Indirect form: low byte from working register, high from port 2.
// [RULE15] pointer_select 0 uses primary pointer, 1 secondary.
// [RULE16] Peripheral holds wait low before sample until ready, then releases.
// [RULE17] Wait sampled only during external_data_move access cycles.
module edswc_ctrl
   import edswc_pkg::*;
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Core side.
   input  wire logic [7:0]  indirect_working_register,
   input  wire logic [7:0]  port2_high_byte,
   // External bus.
   input  wire logic        port4_bit0_wait_n,
   output logic [15:0]      ext_addr,
   output logic             ext_rd_n,
   output logic             ext_wr_n,
   output logic             ext_cycle_active
);
   edswc_state_t state_q;
   logic [2:0]  stretch_q;
   logic        wait_en_q;
   logic        pointer_select_q;
   logic [15:0] primary_data_pointer_q;
   logic [15:0] secondary_data_pointer_q;
   logic        is_write_q;
   logic        use_ptr_q;
   logic [1:0]  phase_q;
   logic [3:0]  mc_left_q;
   logic        wait_hold_q;
   logic        first_mc_q;
   logic        short_q;
   logic [1:0]  unlock_stage_q;
   logic [2:0]  unlock_win_q;
   logic [31:0] access_count_q;
   logic        wait_sync;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_fire;
   logic        go_cmd;
   logic [15:0] sel_addr;
   logic        c3;
   logic        wait_now;
   logic        acc_done;

   // [RULE5]
   edswc_sync #(.RST_VAL(1'b1)) u_wait_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (port4_bit0_wait_n),
      .q       (wait_sync)
   );

   // Write channel: address and data are taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
      end
   end

   assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign go_cmd  = wr_fire && awaddr_q == `EDSWC_CMD_OFFS && wstrb_q[0]
                    && wdata_q[`EDSWC_CMD_GO_BIT] && state_q == EDSWC_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
         s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q > `EDSWC_CMD_OFFS || awaddr_q[1:0] != 2'b00)
                            ? 2'b10 : 2'b00;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software settings. Byte lane 0 carries the narrow fields.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stretch_q                <= `EDSWC_STRETCH_RST; // [RULE2]
         pointer_select_q         <= 1'b0;
         primary_data_pointer_q   <= 16'h0000;
         secondary_data_pointer_q <= 16'h0000;
      end else if (wr_fire) begin
         if (awaddr_q == `EDSWC_CLKCTL_OFFS && wstrb_q[0]) begin
            stretch_q <= wdata_q[`EDSWC_STRETCH_MSB:0]; // [RULE13]
         end
         if (awaddr_q == `EDSWC_DPSEL_OFFS && wstrb_q[0]) begin
            pointer_select_q <= wdata_q[0];
         end
         if (awaddr_q == `EDSWC_DPTR0_OFFS) begin
            if (wstrb_q[0]) primary_data_pointer_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) primary_data_pointer_q[15:8] <= wdata_q[15:8];
         end
         if (awaddr_q == `EDSWC_SECONDARY_DATA_POINTER_OFFS) begin
            if (wstrb_q[0]) secondary_data_pointer_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) secondary_data_pointer_q[15:8] <= wdata_q[15:8];
         end
      end
   end

   // Timed access: key1 then key2 opens a short window for one protected write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unlock_stage_q <= 2'd0;
         unlock_win_q   <= 3'd0;
         wait_en_q      <= 1'b0;
      end else begin
         if (unlock_win_q != 3'd0) begin
            unlock_win_q <= unlock_win_q - 3'd1;
         end else if (unlock_stage_q == 2'd2) begin
            unlock_stage_q <= 2'd0;
         end
         if (wr_fire && awaddr_q == `EDSWC_UNLOCK_OFFS && wstrb_q[0]) begin
            if (wdata_q[7:0] == `EDSWC_UNLOCK_KEY1) begin
               unlock_stage_q <= 2'd1;
               unlock_win_q   <= `EDSWC_UNLOCK_WIN;
            end else if (wdata_q[7:0] == `EDSWC_UNLOCK_KEY2 && unlock_stage_q == 2'd1
                         && unlock_win_q != 3'd0) begin
               unlock_stage_q <= 2'd2;
               unlock_win_q   <= `EDSWC_UNLOCK_WIN;
            end else begin
               unlock_stage_q <= 2'd0;
            end
         end
         if (wr_fire && awaddr_q == `EDSWC_ROM_MAPPING_CONTROL_OFFS && wstrb_q[0]) begin
            if (unlock_stage_q == 2'd2 && unlock_win_q != 3'd0) begin
               wait_en_q <= wdata_q[`EDSWC_WAITEN_BIT]; // [RULE11]
            end
            unlock_stage_q <= 2'd0;
            unlock_win_q   <= 3'd0;
         end
      end
   end

   // Address source: pointer form picks a data pointer, else port 2 and register.
   always_comb begin
      if (wdata_q[`EDSWC_CMD_PTR_BIT]) begin
         sel_addr = pointer_select_q ? secondary_data_pointer_q
                                     : primary_data_pointer_q; // [RULE15]
      end else begin
         sel_addr = {port2_high_byte, indirect_working_register}; // [RULE14]
      end
   end

   assign c3 = phase_q == `EDSWC_C3_PHASE;

   // Access sequencer. One command models one external_data_move; other
   // instructions never pass through here, so their timing is unaffected.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q          <= EDSWC_IDLE;
         phase_q          <= 2'd0;
         mc_left_q        <= 4'd0;
         wait_hold_q      <= 1'b0;
         is_write_q       <= 1'b0;
         use_ptr_q        <= 1'b0;
         ext_addr         <= 16'h0000;
         ext_cycle_active <= 1'b0;
         access_count_q   <= 32'h0000_0000;
      end else begin
         phase_q <= (state_q == EDSWC_IDLE) ? 2'd0 : phase_q + 2'd1;
         case (state_q)
            EDSWC_IDLE: begin
               if (go_cmd) begin
                  state_q          <= EDSWC_FETCH; // [RULE1]
                  is_write_q       <= wdata_q[`EDSWC_CMD_WR_BIT];
                  use_ptr_q        <= wdata_q[`EDSWC_CMD_PTR_BIT];
                  ext_addr         <= sel_addr;
                  ext_cycle_active <= 1'b1;
                  phase_q          <= 2'd0;
               end
            end
            EDSWC_FETCH: begin
               if (phase_q == `EDSWC_CLK_PER_MC) begin
                  state_q     <= EDSWC_ACCESS; // [RULE12]
                  mc_left_q   <= {1'b0, stretch_q} + 4'd1; // [RULE4]
                  wait_hold_q <= 1'b0;
               end
            end
            EDSWC_ACCESS: begin
               if (c3 && wait_en_q && !wait_sync && mc_left_q == 4'd1) begin
                  wait_hold_q <= 1'b1; // [RULE8] [RULE9] [RULE17]
               end else if (c3 && mc_left_q == 4'd1) begin
                  wait_hold_q <= 1'b0; // [RULE6]
               end
               if (phase_q == `EDSWC_CLK_PER_MC) begin
                  if (mc_left_q > 4'd1) begin
                     mc_left_q <= mc_left_q - 4'd1; // [RULE7]
                  end else if (!wait_hold_q) begin
                     state_q          <= EDSWC_IDLE; // [RULE10]
                     ext_cycle_active <= 1'b0;
                     access_count_q   <= access_count_q + 32'd1;
                  end
               end
            end
            default: state_q <= EDSWC_IDLE;
         endcase
      end
   end

   // Strobe spans the final 4*S clocks of the access at S>0; at S=0 it spans 2 clocks ending one clock early. It
   // stays low through inserted wait cycles. Releasing it only after the
   // third_clock_state sample of the last machine cycle means the wait pin is always sampled ahead of the
   // strobe's rising edge, whatever the stretch value.
   assign wait_now = c3 && wait_en_q && !wait_sync;
   assign acc_done = phase_q == `EDSWC_CLK_PER_MC && mc_left_q == 4'd1 && !wait_hold_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_mc_q <= 1'b0;
         short_q    <= 1'b0;
         ext_rd_n   <= 1'b1;
         ext_wr_n   <= 1'b1;
      end else if (state_q == EDSWC_ACCESS) begin
         if (phase_q == `EDSWC_CLK_PER_MC) begin
            first_mc_q <= 1'b0;
         end
         if (first_mc_q && phase_q == (short_q ? 2'd0 : `EDSWC_CLK_PER_MC)) begin
            ext_rd_n <= is_write_q; // [RULE4]
            ext_wr_n <= !is_write_q;
         end else if (short_q ? (c3 && !wait_now) : acc_done) begin
            ext_rd_n <= 1'b1; // [RULE8]
            ext_wr_n <= 1'b1;
         end
      end else begin
         // The shape is latched during the fetch, so a stretch write made
         // mid-access cannot leave the strobe half formed.
         first_mc_q <= 1'b1;
         short_q    <= (stretch_q == 3'd0); // [RULE3]
         ext_rd_n   <= 1'b1;
         ext_wr_n   <= 1'b1;
      end
   end

   // Read channel: one cycle to answer, unmapped words read zero with SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               `EDSWC_CLKCTL_OFFS:  s_axi_rdata <= {29'd0, stretch_q};
               `EDSWC_ROM_MAPPING_CONTROL_OFFS:  s_axi_rdata <= {24'd0, wait_en_q, 7'd0};
               `EDSWC_UNLOCK_OFFS:  s_axi_rdata <= {30'd0, unlock_stage_q};
               `EDSWC_DPSEL_OFFS:   s_axi_rdata <= {31'd0, pointer_select_q};
               `EDSWC_DPTR0_OFFS:   s_axi_rdata <= {16'd0, primary_data_pointer_q};
               `EDSWC_SECONDARY_DATA_POINTER_OFFS:   s_axi_rdata <= {16'd0, secondary_data_pointer_q};
               `EDSWC_ADDRSRC_OFFS: s_axi_rdata <= {16'd0, ext_addr};
               `EDSWC_CMD_OFFS:     s_axi_rdata <= {29'd0, use_ptr_q, is_write_q,
                                                    ext_cycle_active};
               `EDSWC_STATUS_OFFS:  s_axi_rdata <= access_count_q;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [edswc_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module edswc_ctrl_chk (
   // Clock and reset.
   input wire logic        aclk,
   input wire logic        aresetn,
   // External bus.
   input wire logic [15:0] ext_addr,
   input wire logic        ext_rd_n,
   input wire logic        ext_wr_n,
   input wire logic        ext_cycle_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire stb = !ext_rd_n || !ext_wr_n;
   property p_quiet; !ext_cycle_active |-> ext_rd_n && ext_wr_n; endproperty
   a_quiet: assert property (p_quiet)
      else $error("strobe outside an access");
   property p_one_dir; !(!ext_rd_n && !ext_wr_n); endproperty
   a_one_dir: assert property (p_one_dir)
      else $error("read and write strobes together");
   property p_fetch; $rose(ext_cycle_active) |-> !stb[*4]; endproperty
   a_fetch: assert property (p_fetch)
      else $error("strobe during the fetch cycle");
   property p_min_len; $rose(ext_cycle_active) |-> ext_cycle_active[*8]; endproperty
   a_min_len: assert property (p_min_len)
      else $error("access shorter than two machine cycles");
   property p_stb_min; $rose(stb) |-> stb[*2]; endproperty
   a_stb_min: assert property (p_stb_min)
      else $error("strobe shorter than two clocks");
   property p_stb_end; $fell(stb) |-> ##[0:1] !ext_cycle_active; endproperty
   a_stb_end: assert property (p_stb_end)
      else $error("access runs on after the strobe");
   property p_addr; ext_cycle_active && $past(ext_cycle_active) |-> $stable(ext_addr); endproperty
   a_addr: assert property (p_addr)
      else $error("address moved during an access");
   property p_stb_late; $rose(stb) |-> $past(ext_cycle_active, 4); endproperty
   a_stb_late: assert property (p_stb_late)
      else $error("strobe before the fetch cycle ended");
   c_acc: cover property ($rose(ext_cycle_active));
   c_rd: cover property ($fell(ext_rd_n));
   c_wr: cover property ($fell(ext_wr_n));
endmodule
bind edswc_ctrl edswc_ctrl_chk chk_u (.aclk, .aresetn, .ext_addr, .ext_rd_n, .ext_wr_n,
                                      .ext_cycle_active);
`default_nettype wire

// [edswc_periph.sv]
`timescale 1ns/1ps
`default_nettype none
module edswc_periph (
   // Clock and reset.
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Bus view and hold length in clocks.
   input  wire logic       ext_cycle_active,
   input  wire logic [7:0] hold_clks,
   // Wait pin; the line is pulled up while released.
   output logic            wait_n
);
   logic       act_q;
   logic [7:0] cnt_q;
   // Held low from the access start, because the device sees the pin two clocks late.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= 1'b0;
         cnt_q <= 8'h00;
      end else begin
         act_q <= ext_cycle_active;
         if (ext_cycle_active && !act_q) cnt_q <= hold_clks;
         else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      end
   end
   assign wait_n = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// [tb_ext_data_stretch_wait_ctrl.sv]
`include "edswc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ext_data_stretch_wait_ctrl import edswc_pkg::*;;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        ext_rd_n, ext_wr_n, ext_cycle_active, wait_n;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  ri, p2, hold;
   logic [15:0] ext_addr, a, a_seen;
   logic [33:0] rd_q[$], acc_q[$], wr_q[$];
   int          bad_count = 0, tests_run = 0, n_act = 0, n_stb = 0;
   int          sv[4] = '{0, 2, 7, 1};
   int          nv[4] = '{1, 3, 1, 0};

   always #20 aclk = ~aclk;

   edswc_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .indirect_working_register(ri),
      .port2_high_byte(p2), .port4_bit0_wait_n(wait_n), .ext_addr, .ext_rd_n, .ext_wr_n,
      .ext_cycle_active);
   edswc_periph periph_u (.aclk, .aresetn, .ext_cycle_active, .hold_clks(hold), .wait_n);

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] e = 2'b00);
      logic ta, tw, bv;
      bv = 1'b0;
      wr_q.push_back({32'h0000_0000, e});
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!bv) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         bv = s_axi_bvalid;
         @(posedge aclk);
         s_axi_bready <= !bv;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
   endtask

   task automatic rd(input logic [11:0] ad, input logic [33:0] e);
      logic ta, rv;
      rv = 1'b0;
      rd_q.push_back(e);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      while (!rv) begin
         @(negedge aclk);
         ta = s_axi_arready;
         rv = s_axi_rvalid;
         @(posedge aclk);
         s_axi_rready <= !rv;
         if (ta) s_axi_arvalid <= 1'b0;
      end
   endtask

   // Wait cycles count only when enabled, yet the partner pulls the pin either way.
   task automatic go(input logic [2:0] c, input logic [15:0] ea, input int s, w,
                     input logic en);
      int n;
      n = en ? w : 0;
      hold <= (w == 0) ? 8'h00 : 8'(4 * (s + w) + 3);
      acc_q.push_back({2'b00, 8'(4 * (s + 2 + n)), 8'(s == 0 ? 2 + 4 * n : 4 * (s + n)), ea});
      wr(`EDSWC_CMD_OFFS, {29'h0, c});
      while (acc_q.size() != 0) @(posedge aclk);
   endtask

   always @(negedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk({32'h0000_0000, s_axi_bresp}, wr_q.pop_front());
      end
      if (ext_cycle_active) begin
         n_act++;
         n_stb += (!ext_rd_n || !ext_wr_n);
         a_seen = ext_addr;
      end else if (n_act != 0) begin
         chk({2'b00, n_act[7:0], n_stb[7:0], a_seen},
             acc_q.pop_front());
         n_act = 0;
         n_stb = 0;
      end
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ri, p2, hold} = 80'h0;
      s_axi_wstrb = 4'hf;
      void'($urandom(32'h7474_8c80));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(`EDSWC_CLKCTL_OFFS, {2'b00, 32'h0000_0001});
      rd(12'h0fc, {2'b10, 32'h0000_0000});
      a = 16'($urandom);
      wr(`EDSWC_DPTR0_OFFS, {16'h0000, a});
      go(3'b101, a, 1, 0, 1'b0);
      for (int s = 0; s < 8; s++) begin
         wr(`EDSWC_CLKCTL_OFFS, 32'(s));
         a = 16'($urandom);
         wr(`EDSWC_DPTR0_OFFS, {16'h0000, a});
         go({1'b1, 1'($urandom), 1'b1}, a, s, 0, 1'b0);
      end
      wr(`EDSWC_CLKCTL_OFFS, 32'h0000_0002);
      wr(`EDSWC_DPSEL_OFFS, 32'h0000_0001);
      a = 16'($urandom);
      wr(`EDSWC_SECONDARY_DATA_POINTER_OFFS, {16'h0000, a});
      go(3'b111, a, 2, 0, 1'b0);
      a = 16'($urandom);
      ri <= a[7:0];
      p2 <= a[15:8];
      go(3'b011, a, 2, 2, 1'b0);
      wr(`EDSWC_ROM_MAPPING_CONTROL_OFFS, 32'h0000_0080);
      rd(`EDSWC_ROM_MAPPING_CONTROL_OFFS, {2'b00, 32'h0000_0000});
      wr(`EDSWC_UNLOCK_OFFS, 32'h0000_00aa);
      wr(`EDSWC_UNLOCK_OFFS, 32'h0000_0055);
      wr(`EDSWC_ROM_MAPPING_CONTROL_OFFS, 32'h0000_0080);
      rd(`EDSWC_ROM_MAPPING_CONTROL_OFFS, {2'b00, 32'h0000_0080});
      for (int i = 0; i < 4; i++) begin
         wr(`EDSWC_CLKCTL_OFFS, 32'(sv[i]));
         go({1'b0, 1'($urandom), 1'b1}, a, sv[i], nv[i], 1'b1);
      end
      wr(12'h0fc, 32'h0000_0000, 2'b10);
      rd(`EDSWC_ADDRSRC_OFFS, {18'h0_0000, a});
      rd(`EDSWC_STATUS_OFFS, {2'b00, 32'h0000_000f});
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      give_verdict;
   end
endmodule
`default_nettype wire
